// ===== rtl/rtcfc_pkg.sv
// Purpose: shared constants and types of the rtc function control block
// Assumes: 200 MHz system clock, 32.768 kHz oscillator level sampled synchronously
// Notes:   function control word packs exactly as its register bits 7..0

package rtcfc_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] FUNC_CTRL_ADDR  = 8'h28;
    localparam logic [7:0] FLAGS_ADDR      = 8'h2B;
    localparam logic [7:0] FUNC_CTRL_RESET = 8'h00;
    localparam int         FLAG_PIF_BIT    = 7;

    // ------------------------------------------------------------
    // field encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RTCFC_PI_NONE = 2'h0,
        RTCFC_PI_SEC  = 2'h1,
        RTCFC_PI_MIN  = 2'h2,
        RTCFC_PI_HOUR = 2'h3
    } rtcfc_pi_t;

    localparam logic [2:0] COF_STATIC   = 3'h7;
    localparam logic [1:0] TS_MODE_INTERRUPT_B_PIN = 2'h1;
    localparam logic [1:0] TS_MODE_CLK  = 2'h2;
    localparam logic [1:0] TS_MODE_IN   = 2'h3;
    localparam logic [1:0] INTERRUPT_A_PIN_MODE_CK = 2'h0;
    localparam logic [1:0] INTERRUPT_A_PIN_MODE_IRQ = 2'h2;

    // ------------------------------------------------------------
    // timing counts
    // ------------------------------------------------------------
    localparam int          PRESCALE_BITS  = 15;
    localparam int          TAP_1HZ        = 14;
    localparam logic [6:0]  TICK256_MASK   = 7'h7F;
    localparam logic [11:0] SEC_LAST_MIN   = 12'h03B;
    localparam logic [11:0] SEC_LAST_HOUR  = 12'hE0F;
    localparam logic [1:0]  FRAC_LONG_DIV  = 2'h3;
    localparam logic [1:0]  FRAC_SHORT_DIV = 2'h2;
    localparam logic [4:0]  FRAC_LONG_CNT  = 5'h0E;
    localparam logic [4:0]  FRAC_CYCLE_CNT = 5'h19;
    localparam logic [6:0]  FRAC_SUM_LAST  = 7'h3F;
    localparam logic [19:0] HOUR_LIMIT_CAL = 20'h0_0017;
    localparam logic [19:0] HOUR_LIMIT_SW  = 20'hF_423F;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic       hundredths_mode;
        rtcfc_pi_t  periodic_irq_select;
        logic       count_mode_select;
        logic       stop_source_select;
        logic [2:0] clkout_freq_select;
    } rtcfc_func_t;

    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } rtcfc_reg_req_t;

    typedef struct packed {
        logic       clk_pin_disable;
        logic       clkout_invert;
        logic [1:0] ts_pin_io_mode;
        logic       ts_active_level;
        logic [1:0] interrupt_a_pin_pin_mode;
    } rtcfc_pin_cfg_t;

endpackage

// ===== rtl/rtcfc_prescaler.sv
// Purpose: divides the oscillator into square-wave taps and tick pulses
// Assumes: osc_level is synchronous to clk and far slower than it
// Notes:   taps are plain counter bits, so every divided wave is 50:50

`timescale 1ns/100ps
`default_nettype none

module rtcfc_prescaler (
    // clock and reset
    input  wire logic                                clk,
    input  wire logic                                reset_n,
    input  wire logic                                ce,
    // oscillator
    input  wire logic                                osc_level,
    // divided outputs
    output logic [rtcfc_pkg::PRESCALE_BITS-1:0]      taps,
    output logic                                     tick_256,
    output logic                                     tick_1hz
);

    logic osc_prev;
    logic osc_rise;

    assign osc_rise = ce & osc_level & ~osc_prev;
    assign tick_256 = osc_rise & (taps[6:0] == rtcfc_pkg::TICK256_MASK);
    assign tick_1hz = osc_rise & (&taps);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            osc_prev <= 1'b0;
            taps     <= '0;
        end else if (ce) begin
            osc_prev <= osc_level;
            if (osc_rise) begin
                taps <= taps + 1'b1;
            end
        end
    end

    AST_TAP_1HZ_HALF: assert property (@(posedge clk) disable iff (!reset_n)
        tick_1hz |=> !taps[rtcfc_pkg::TAP_1HZ])
        else $error("1 Hz tap did not fall at the second boundary");

endmodule

`default_nettype wire

// ===== rtl/rtcfc_frac_div.sv
// Purpose: fractional divider making the 100 Hz tick from the 256 Hz tick
// Assumes: tick_256 already carries the clock enable
// Notes:   14 periods of 3 then 11 periods of 2 make 64 inputs per 25 outputs

`timescale 1ns/100ps
`default_nettype none

module rtcfc_frac_div (
    // clock and reset
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic ce,
    // ticks
    input  wire logic tick_256,
    output logic      tick_100
);

    typedef enum logic {
        RTCFC_FR_LONG  = 1'b0,
        RTCFC_FR_SHORT = 1'b1
    } rtcfc_frac_state_t;

    rtcfc_frac_state_t state;
    rtcfc_frac_state_t next_state;
    logic [1:0]        phase;
    logic [4:0]        index;
    logic [1:0]        div_last;
    logic              last_tick;
    logic [6:0]        sum_in;

    assign div_last  = (state == RTCFC_FR_LONG) ? rtcfc_pkg::FRAC_LONG_DIV - 2'h1
                                                : rtcfc_pkg::FRAC_SHORT_DIV - 2'h1;
    assign tick_100  = tick_256 & (phase == div_last);
    assign last_tick = (index == rtcfc_pkg::FRAC_CYCLE_CNT - 5'h01);

    always_comb begin
        next_state = state;
        unique case (state)
            RTCFC_FR_LONG: begin
                if (index == rtcfc_pkg::FRAC_LONG_CNT - 5'h01) begin
                    next_state = RTCFC_FR_SHORT;
                end
            end
            RTCFC_FR_SHORT: begin
                if (last_tick) begin
                    next_state = RTCFC_FR_LONG;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= RTCFC_FR_LONG;
            phase <= 2'h0;
            index <= 5'h00;
        end else if (ce && tick_256) begin
            phase <= tick_100 ? 2'h0 : phase + 2'h1;
            if (tick_100) begin
                state <= next_state;
                index <= last_tick ? 5'h00 : index + 5'h01;
            end
        end
    end

    // helper: input ticks seen inside one 25-output cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sum_in <= 7'h00;
        end else if (tick_256) begin
            sum_in <= (tick_100 && last_tick) ? 7'h00 : sum_in + 7'h01;
        end
    end

    AST_FRAC_ZERO_JITTER: assert property (@(posedge clk) disable iff (!reset_n)
        (tick_100 && last_tick) |-> (sum_in == rtcfc_pkg::FRAC_SUM_LAST))
        else $error("25 outputs did not span 64 input ticks");

endmodule

`default_nettype wire

// ===== rtl/rtcfc_function_control.sv
// Purpose: function control register of the rtc and the logic it steers
// Assumes: register port comes from the serial host interface, one access per strobe
// Notes:   counting itself lives outside; this block hands it ticks and limits

`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - hundredths_mode set exposes hundredths and ticks at 0.01 s, else 1 s.
// - 100 Hz comes from 256 Hz by 14 divides of 3, 11 of 2.
// - periodic select 00 none, 01 second, 10 minute, 11 hour.
// - periodic select 00 holds the periodic timers in reset.
// - first periodic pulse lands between period minus one second and period.
// - periodic timers ignore the counting halt.
// - every periodic pulse sets periodic_irq_flag.
// - periodic pulses repeat even while the flag stays set.
// - periodic pulse width is independent of offset calibration.
// - count mode 0 is full calendar, 1 is hours up to 999999.
// - counting_halt stops counting in both count modes.
// - stop source 0 halts by bit only, 1 by bit or event pin.
// - clkout codes 0 to 6 pick frequencies; code 7 is static low, INTERRUPT_A_PIN released.
// - clock pin is push-pull, active from reset, low when disabled.
// - selected frequency also reaches event pin and INTERRUPT_A_PIN in clock mode.
// - clkout_invert inverts the wave except for code 7.
// - divided outputs are 50:50; only the raw oscillator may deviate.
// - the 1 Hz output gets no offset correction pulses.
// - writing 0 clears periodic_irq_flag, writing 1 leaves it.
module rtcfc_function_control (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      reset_n,
    input  wire logic                      ce,
    // register port
    input  wire rtcfc_pkg::rtcfc_reg_req_t reg_req,
    output logic [7:0]                     reg_rdata,
    output logic                           reg_rvalid,
    // oscillator and neighbouring controls
    input  wire logic                      osc_level,
    input  wire logic                      counting_halt,
    input  wire rtcfc_pkg::rtcfc_pin_cfg_t pin_cfg,
    input  wire logic                      interrupt_a_pin_n_level,
    input  wire logic                      interrupt_b_pin_n_level,
    // timekeeping hand-off
    output logic                           count_tick,
    output logic                           hundredths_visible,
    output logic                           calendar_enable,
    output logic [19:0]                    hour_limit,
    output logic                           periodic_pulse,
    output logic                           periodic_irq_flag,
    // pins
    output logic                           clk_pin_out,
    input  wire logic                      event_input_pin_in,
    output logic                           event_input_pin_out,
    output logic                           event_input_pin_oe,
    output logic                           interrupt_a_pin_out,
    output logic                           interrupt_a_pin_oe
);

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic is_static(input logic [2:0] code);
        return code == rtcfc_pkg::COF_STATIC;
    endfunction

    function automatic logic wave_pick(input logic [2:0] code,
                                       input logic       osc,
                                       input logic [14:0] taps);
        logic w;
        w = 1'b0;
        unique case (code)
            3'h0:    w = osc;
            3'h1:    w = taps[0];
            3'h2:    w = taps[1];
            3'h3:    w = taps[2];
            3'h4:    w = taps[3];
            3'h5:    w = taps[4];
            3'h6:    w = taps[rtcfc_pkg::TAP_1HZ];
            default: w = 1'b0;
        endcase
        return w;
    endfunction

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    rtcfc_pkg::rtcfc_func_t func;
    rtcfc_pkg::rtcfc_func_t next_func;

    logic        hit_func;
    logic        hit_flags;
    logic        wr_func;
    logic        wr_flags;
    logic        flag_clear;
    logic [7:0]  next_rdata;

    assign hit_func   = reg_req.addr == rtcfc_pkg::FUNC_CTRL_ADDR;
    assign hit_flags  = reg_req.addr == rtcfc_pkg::FLAGS_ADDR;
    assign wr_func    = ce & reg_req.wr & hit_func;
    assign wr_flags   = ce & reg_req.wr & hit_flags;
    assign flag_clear = wr_flags & ~reg_req.wdata[rtcfc_pkg::FLAG_PIF_BIT];
    assign next_func  = wr_func ? rtcfc_pkg::rtcfc_func_t'(reg_req.wdata) : func;
    assign next_rdata = hit_func  ? 8'(func) :
                        hit_flags ? {periodic_irq_flag, 7'h00} : 8'h00;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            func <= rtcfc_pkg::rtcfc_func_t'(rtcfc_pkg::FUNC_CTRL_RESET);
        end else if (ce) begin
            func <= next_func;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end else if (ce) begin
            reg_rvalid <= reg_req.rd;
            if (reg_req.rd) begin
                reg_rdata <= next_rdata;
            end
        end
    end

    // ------------------------------------------------------------
    // prescaler and fractional divider
    // ------------------------------------------------------------
    logic [14:0] taps;
    logic        tick_256;
    logic        tick_1hz;
    logic        tick_100;

    rtcfc_prescaler u_prescaler (
        .clk       (clk),
        .reset_n   (reset_n),
        .ce        (ce),
        .osc_level (osc_level),
        .taps      (taps),
        .tick_256  (tick_256),
        .tick_1hz  (tick_1hz)
    );

    rtcfc_frac_div u_frac_div (
        .clk      (clk),
        .reset_n  (reset_n),
        .ce       (ce),
        .tick_256 (tick_256),
        .tick_100 (tick_100)
    );

    // ------------------------------------------------------------
    // halt control and count tick
    // ------------------------------------------------------------
    logic pin_is_input;
    logic pin_halt;
    logic halted;
    logic res_tick;

    assign pin_is_input = pin_cfg.ts_pin_io_mode == rtcfc_pkg::TS_MODE_IN;
    // level 0 means active high, so a pin that differs from it is active and halts
    assign pin_halt     = func.stop_source_select & pin_is_input
                        & (event_input_pin_in ^ pin_cfg.ts_active_level);
    assign halted       = counting_halt | pin_halt;
    assign res_tick     = func.hundredths_mode ? tick_100 : tick_1hz;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_tick <= 1'b0;
        end else if (ce) begin
            count_tick <= res_tick & ~halted;
        end
    end

    assign hundredths_visible = func.hundredths_mode;
    assign calendar_enable    = ~func.count_mode_select;
    assign hour_limit         = func.count_mode_select ? rtcfc_pkg::HOUR_LIMIT_SW
                                                       : rtcfc_pkg::HOUR_LIMIT_CAL;

    // ------------------------------------------------------------
    // periodic interrupt timers
    // ------------------------------------------------------------
    logic [11:0] sec_cnt;
    logic [11:0] sec_last;
    logic        pi_on;
    logic        pi_fire;

    // seconds from the free prescaler, never from the halted count path
    assign pi_on    = func.periodic_irq_select != rtcfc_pkg::RTCFC_PI_NONE;
    assign sec_last = (func.periodic_irq_select == rtcfc_pkg::RTCFC_PI_HOUR) ?
                      rtcfc_pkg::SEC_LAST_HOUR :
                      (func.periodic_irq_select == rtcfc_pkg::RTCFC_PI_MIN) ?
                      rtcfc_pkg::SEC_LAST_MIN : 12'h000;
    assign pi_fire  = pi_on & tick_1hz & (sec_cnt >= sec_last);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sec_cnt <= 12'h000;
        end else if (ce) begin
            if (!pi_on) begin
                sec_cnt <= 12'h000;
            end else if (tick_1hz) begin
                sec_cnt <= pi_fire ? 12'h000 : sec_cnt + 12'h001;
            end
        end
    end

    // fixed one-cycle pulse from the uncorrected prescaler
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            periodic_pulse <= 1'b0;
        end else if (ce) begin
            periodic_pulse <= pi_fire;
        end
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            periodic_irq_flag <= 1'b0;
        end else if (ce) begin
            if (pi_fire) begin
                periodic_irq_flag <= 1'b1;
            end else if (flag_clear) begin
                periodic_irq_flag <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // clock output and pin drivers
    // ------------------------------------------------------------
    logic raw_wave;
    logic cof_static;
    logic out_wave;
    logic next_clk_pin;
    logic next_ts_out;
    logic next_ts_oe;
    logic next_interrupt_a_pin_out;
    logic next_interrupt_a_pin_oe;

    // 1 Hz is a plain prescaler tap, so no correction pulse reaches it
    assign raw_wave   = wave_pick(func.clkout_freq_select, osc_level, taps);
    assign cof_static = is_static(func.clkout_freq_select);
    assign out_wave   = cof_static ? 1'b0 : raw_wave ^ pin_cfg.clkout_invert;

    assign next_clk_pin = ~pin_cfg.clk_pin_disable & out_wave;
    assign next_ts_oe   = (pin_cfg.ts_pin_io_mode == rtcfc_pkg::TS_MODE_CLK)
                        | (pin_cfg.ts_pin_io_mode == rtcfc_pkg::TS_MODE_INTERRUPT_B_PIN);
    assign next_ts_out  = (pin_cfg.ts_pin_io_mode == rtcfc_pkg::TS_MODE_CLK) ? out_wave
                        : (pin_cfg.ts_pin_io_mode == rtcfc_pkg::TS_MODE_INTERRUPT_B_PIN) & interrupt_b_pin_n_level;
    assign next_interrupt_a_pin_out = 1'b0;
    assign next_interrupt_a_pin_oe  = (pin_cfg.interrupt_a_pin_pin_mode == rtcfc_pkg::INTERRUPT_A_PIN_MODE_CK)
                         ? (~cof_static & ~out_wave)
                         : (pin_cfg.interrupt_a_pin_pin_mode == rtcfc_pkg::INTERRUPT_A_PIN_MODE_IRQ) & ~interrupt_a_pin_n_level;

    // open-drain INTERRUPT_A_PIN only ever pulls low
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            clk_pin_out         <= 1'b0;
            event_input_pin_out <= 1'b0;
            event_input_pin_oe  <= 1'b0;
            interrupt_a_pin_out <= 1'b0;
            interrupt_a_pin_oe  <= 1'b0;
        end else if (ce) begin
            clk_pin_out         <= next_clk_pin;
            event_input_pin_out <= next_ts_out;
            event_input_pin_oe  <= next_ts_oe;
            interrupt_a_pin_out <= next_interrupt_a_pin_out;
            interrupt_a_pin_oe  <= next_interrupt_a_pin_oe;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_fire;
        ce && pi_fire;
    endsequence

    sequence s_pulse_set;
        periodic_pulse && periodic_irq_flag;
    endsequence

    AST_RES_TICK: assert property (@(posedge clk) disable iff (!reset_n)
        count_tick |-> ($past(func.hundredths_mode) ? $past(tick_100) : $past(tick_1hz)))
        else $error("count tick not at the selected resolution");

    AST_PI_OFF_RESET: assert property (@(posedge clk) disable iff (!reset_n)
        (ce && !pi_on) |=> (sec_cnt == 12'h000))
        else $error("periodic timer not held while disabled");

    AST_PI_SEC_EVERY: assert property (@(posedge clk) disable iff (!reset_n)
        (ce && tick_1hz && func.periodic_irq_select == rtcfc_pkg::RTCFC_PI_SEC)
        |=> periodic_pulse)
        else $error("per-second pulse missing");

    AST_PI_MIN_SPAN: assert property (@(posedge clk) disable iff (!reset_n)
        pi_fire |-> (func.periodic_irq_select != rtcfc_pkg::RTCFC_PI_MIN
                     || sec_cnt == 12'h03B))
        else $error("minute pulse not after 60 seconds");

    AST_FLAG_SET: assert property (@(posedge clk) disable iff (!reset_n)
        s_fire |=> s_pulse_set)
        else $error("periodic fire did not pulse and set the flag");

    AST_FLAG_CLEAR: assert property (@(posedge clk) disable iff (!reset_n)
        (flag_clear && !pi_fire) |=> !periodic_irq_flag)
        else $error("write of zero did not clear the flag");

    AST_FLAG_KEEP: assert property (@(posedge clk) disable iff (!reset_n)
        (ce && wr_flags && reg_req.wdata[7] && periodic_irq_flag) |=> periodic_irq_flag)
        else $error("write of one disturbed the flag");

    AST_HALT_STOPS: assert property (@(posedge clk) disable iff (!reset_n)
        (ce && counting_halt) |=> !count_tick)
        else $error("count tick while halted");

    AST_PIN_HALT: assert property (@(posedge clk) disable iff (!reset_n)
        (ce && func.stop_source_select && pin_is_input
         && event_input_pin_in != pin_cfg.ts_active_level) |=> !count_tick)
        else $error("event pin failed to halt counting");

    AST_STATIC_LOW: assert property (@(posedge clk) disable iff (!reset_n)
        (ce && cof_static) |=> (!clk_pin_out && !(interrupt_a_pin_oe
                                && pin_cfg.interrupt_a_pin_pin_mode == rtcfc_pkg::INTERRUPT_A_PIN_MODE_CK)))
        else $error("static code did not hold clock low and release INTERRUPT_A_PIN");

    AST_CLK_DISABLE: assert property (@(posedge clk) disable iff (!reset_n)
        (ce && pin_cfg.clk_pin_disable) |=> !clk_pin_out)
        else $error("disabled clock pin not low");

    AST_INVERT: assert property (@(posedge clk) disable iff (!reset_n)
        (ce && reset_n && !cof_static && !pin_cfg.clk_pin_disable)
        |=> (clk_pin_out == ($past(raw_wave) ^ $past(pin_cfg.clkout_invert))))
        else $error("clock pin polarity wrong");

    AST_TS_CLOCK: assert property (@(posedge clk) disable iff (!reset_n)
        (ce && pin_cfg.ts_pin_io_mode == rtcfc_pkg::TS_MODE_CLK)
        |=> (event_input_pin_oe && event_input_pin_out == $past(out_wave)))
        else $error("event pin not carrying the clock");

endmodule

`default_nettype wire

// ===== test/rtcfc_host.sv
// Purpose: host model issuing single-byte register accesses
// Assumes: one strobe cycle per access, read answer one cycle later
// Notes:   released address and data lines carry inverted values, never the last ones
`timescale 1ns/100ps
`default_nettype none
module rtcfc_host (
    // clock
    input  wire logic                     clk,
    // register port
    output var rtcfc_pkg::rtcfc_reg_req_t reg_req,
    input  wire logic [7:0]               reg_rdata,
    input  wire logic                     reg_rvalid
);
    initial reg_req = '{addr: 8'hFF, wr: 1'b0, rd: 1'b0, wdata: 8'h00};
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) reg_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(posedge clk) reg_req <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
    endtask
    task automatic rd(input logic [7:0] a, output logic [8:0] dv);
        @(posedge clk) reg_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(posedge clk) reg_req <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: 8'hFF};
        @(negedge clk) dv = {reg_rvalid, reg_rdata};
    endtask
endmodule
`default_nettype wire

// ===== test/tb_top.sv
// Purpose: self-checking bench of the rtc function control block
// Assumes: oscillator level toggles every clk, so one second is 65536 clk
// Notes:   ce is tied high and both interrupt levels are tied inactive
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic clk = 0, reset_n = 0, osc_level = 0, counting_halt = 0, ev_in = 0;
    logic [8:0] dv;
    int failures = 0, tests_run = 0, c;
    rtcfc_pkg::rtcfc_reg_req_t req;
    rtcfc_pkg::rtcfc_pin_cfg_t cfg = '0;
    logic [7:0] rdata;
    logic rvalid, tick, hvis, cal, pp, flag, clkp, ev_out, ev_oe, ia_out, ia_oe;
    logic [19:0] hlim;
    initial forever #2.5 clk = ~clk;
    always @(posedge clk) osc_level <= ~osc_level;
    rtcfc_host host (.clk(clk), .reg_req(req), .reg_rdata(rdata), .reg_rvalid(rvalid));
    rtcfc_function_control dut (.clk(clk), .reset_n(reset_n), .ce(1'b1), .reg_req(req),
        .reg_rdata(rdata), .reg_rvalid(rvalid), .osc_level(osc_level),
        .counting_halt(counting_halt), .pin_cfg(cfg), .interrupt_a_pin_n_level(1'b1),
        .interrupt_b_pin_n_level(1'b1), .count_tick(tick), .hundredths_visible(hvis),
        .calendar_enable(cal), .hour_limit(hlim), .periodic_pulse(pp),
        .periodic_irq_flag(flag), .clk_pin_out(clkp), .event_input_pin_in(ev_in),
        .event_input_pin_out(ev_out), .event_input_pin_oe(ev_oe),
        .interrupt_a_pin_out(ia_out), .interrupt_a_pin_oe(ia_oe));
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic ticks(output int n);
        n = 0;
        @(posedge clk);
        repeat (1000) @(negedge clk) n += (tick !== 1'b0) ? 1 : 0;
    endtask
    task report_and_stop;
        if (failures == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #450000;
        failures++;
        report_and_stop();
    end
    initial begin
        repeat (4) @(posedge clk);
        reset_n <= 1;
        host.rd(8'h28, dv); cmp(dv, 9'h100);
        cmp(hlim, 20'h0_0017); cmp(cal, 1);
        host.wr(8'h28, 8'h9F); host.rd(8'h28, dv); cmp(dv, 9'h19F);
        repeat (3) @(negedge clk);
        cmp({hvis, cal}, 2'b10); cmp(hlim, 20'hF_423F);
        cmp({clkp, ia_oe}, 2'b00);
        @(posedge clk) cfg.ts_pin_io_mode <= 2'h3; ev_in <= 1;
        ticks(c); cmp(c, 0);
        @(posedge clk) ev_in <= 0; ticks(c); cmp(c != 0, 1);
        @(posedge clk) counting_halt <= 1; ticks(c); cmp(c, 0);
        host.wr(8'h28, 8'hA8);
        c = 0;
        while (pp !== 1'b1 && c < 70000) begin
            @(negedge clk);
            c++;
        end
        cmp(pp, 1); cmp(flag, 1);
        host.wr(8'h2B, 8'h80); host.rd(8'h2B, dv); cmp(dv, 9'h180);
        host.wr(8'h2B, 8'h00); host.rd(8'h2B, dv); cmp(dv, 9'h100);
        host.rd(8'h30, dv); cmp(dv, 9'h100);
        @(posedge clk) cfg <= '{1'b0, 1'b1, 2'h2, 1'b0, 2'h0};
        repeat (2) @(negedge clk);
        cmp({clkp, ev_out, ev_oe, ia_oe, ia_out},
            {osc_level, osc_level, 1'b1, ~osc_level, 1'b0});
        @(posedge clk) cfg.clk_pin_disable <= 1'b1;
        repeat (2) @(negedge clk);
        cmp({clkp, ev_out}, {1'b0, osc_level});
        report_and_stop();
    end
endmodule
`default_nettype wire
